// >>> rtl/sfp_pkg.sv
// Shared constants and types for the serial flash program and erase sequencer
package sfp_pkg;
  // Command opcodes
  localparam logic [7:0] OP_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLK4K      = 8'h20;
  localparam logic [7:0] OP_BLK32K_A   = 8'h52;
  localparam logic [7:0] OP_BLK32K_B   = 8'hd8;
  localparam logic [7:0] OP_WREN       = 8'h06;
  localparam logic [7:0] OP_WRDI       = 8'h04;
  // Frame byte counts (opcode included)
  localparam logic [2:0] PROG_MIN_BYTES  = 3'h5;
  localparam logic [2:0] ERASE_MIN_BYTES = 3'h4;
  localparam logic [2:0] CNT_SAT         = 3'h6;
  // Array geometry
  localparam int         ADDR_W       = 24;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;
  localparam logic [16:0] LEN_PAGE    = 17'h00100;
  localparam logic [16:0] LEN_BLK4K   = 17'h01000;
  localparam logic [16:0] LEN_BLK32K  = 17'h08000;
  // Cycles allowed for the last byte to cross after chip select rises
  localparam logic [2:0] CLOSE_WAIT   = 3'h4;
  // Self-timed durations in microseconds, and clock rate
  localparam int CLK_MHZ      = 40;
  localparam int T_BP_US      = 100;
  localparam int T_PP_US      = 1000;
  localparam int T_PE_US      = 1000;
  localparam int T_BLK4K_US   = 5000;
  localparam int T_BLK32K_US  = 20000;
  localparam int BP_CYC       = T_BP_US * CLK_MHZ;
  localparam int PP_CYC       = T_PP_US * CLK_MHZ;
  localparam int PE_CYC       = T_PE_US * CLK_MHZ;
  localparam int BLK4K_CYC    = T_BLK4K_US * CLK_MHZ;
  localparam int BLK32K_CYC   = T_BLK32K_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ARR_IDLE, ARR_WRITE, ARR_READ, ARR_ERASE_PAGE, ARR_ERASE_4K, ARR_ERASE_32K
  } sfp_arr_op_t;

  typedef struct packed {
    sfp_arr_op_t        op;
    logic [ADDR_W-1:0]  addr;
    logic [7:0]         data;
  } sfp_arr_req_t;

  typedef struct packed {
    logic        stb;
    logic [7:0]  data;
  } sfp_rx_t;

  typedef enum {ST_IDLE, ST_RECV, ST_CLOSE, ST_WRITE, ST_VERIFY, ST_WAIT} sfp_state_t;
endpackage : sfp_pkg

// >>> rtl/sfp_spi_link.sv
// Serial link front end: shifts bytes on the link clock and hands them to sys_clk
`timescale 1ns/100ps
module sfp_spi_link (
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  input  wire logic      spi_sck,
  input  wire logic      spi_cs_n,
  input  wire logic      spi_mosi,
  output sfp_pkg::sfp_rx_t rx,
  output logic           cs_fall,
  output logic           cs_rise,
  output logic           partial
);
  logic       first_q;
  logic [2:0] bcnt_q;
  logic [6:0] sh_q;
  logic [7:0] hold_q;
  logic       tog_q;
  logic       part_q;
  logic       tog_s1_q, tog_s2_q, tog_s3_q;
  logic       cs_s1_q, cs_s2_q, cs_s3_q;
  logic       part_s1_q, part_s2_q;

  // Link logic clears its frame state while chip select is high
  wire       lnk_rst = sys_rst | spi_cs_n;
  wire [2:0] bcnt_eff = first_q ? 3'h0 : bcnt_q;
  wire [2:0] bnext    = bcnt_eff + 3'h1;

  // First-edge marker, set while the frame is closed
  always_ff @(posedge spi_sck or posedge lnk_rst) begin
    if (lnk_rst) first_q <= 1'b1;
    else         first_q <= 1'b0;
  end

  // Shift in MSB first on rising clock; toggle marks each whole byte
  always_ff @(posedge spi_sck or posedge sys_rst) begin
    if (sys_rst) begin
      bcnt_q <= 3'h0;
      sh_q   <= 7'h00;
      hold_q <= 8'h00;
      tog_q  <= 1'b0;
      part_q <= 1'b0;
    end else begin
      bcnt_q <= bnext;
      sh_q   <= {sh_q[5:0], spi_mosi};
      part_q <= (bnext != 3'h0);
      if (bcnt_eff == 3'h7) begin
        hold_q <= {sh_q, spi_mosi};
        tog_q  <= ~tog_q;
      end
    end
  end

  // Synchronisers into sys_clk; held byte is stable for several link periods
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {tog_s1_q, tog_s2_q, tog_s3_q} <= 3'h0;
      {cs_s1_q, cs_s2_q, cs_s3_q}    <= 3'h7;
      {part_s1_q, part_s2_q}         <= 2'h0;
    end else begin
      {tog_s1_q, tog_s2_q, tog_s3_q} <= {tog_q, tog_s1_q, tog_s2_q};
      {cs_s1_q, cs_s2_q, cs_s3_q}    <= {spi_cs_n, cs_s1_q, cs_s2_q};
      {part_s1_q, part_s2_q}         <= {part_q, part_s1_q};
    end
  end

  // Events in the system domain
  assign rx.stb  = tog_s2_q ^ tog_s3_q;
  assign rx.data = hold_q;
  assign cs_fall = cs_s3_q & ~cs_s2_q;
  assign cs_rise = ~cs_s3_q & cs_s2_q;
  assign partial = part_s2_q;
endmodule : sfp_spi_link

// >>> rtl/sfp_sequencer.sv
// Program and erase command sequencer of a serial flash device
// What this block does
// - Program runs only when the write enable latch is already set.
// - Data pointer wraps from page end to start of the same page.
// - More than 256 data bytes keeps only the last 256 received.
// - Buffered bytes are written at start page locations; others stay untouched.
// - Program aborts without full address, one data byte, byte-aligned release.
// - Protected array: program not executed, device returns to idle.
// - Program aborts for short address, data, misalignment, protection clear the latch.
// - Programming is self-timed, single byte and page having separate times.
// - Status shows busy while programming; host should poll.
// - Write enable latch clears before a program cycle ends.
// - Every programmed byte is checked; failure sets the error flag.
// - Page erase sets the page selected by address bits 16 to 8 to ones while busy shows; bits 23 to 17 are taken as zero.
// - Erase failures at any byte set the error flag.
// - Opcode 20h erases 4 KB block; 52h or D8h erase 32 KB.
// - Block erase runs only when the write enable latch is set.
// - Low 12 or 15 address bits ignored for 4 KB or 32 KB erase.
// - Erase aborts without full address or aligned release; extra bytes ignored.
// - Protected array: block erase not executed, device returns to idle.
// - Erase aborts for short address, misalignment or protection clear the latch.
// - Busy shows during erase; latch clears before the erase completes.
// - Write enable opcode with aligned release sets the latch.
// - Protect bit set protects the whole array against program and erase.
`timescale 1ns/100ps
module sfp_sequencer #(
  parameter int BP_CYC     = sfp_pkg::BP_CYC,
  parameter int PP_CYC     = sfp_pkg::PP_CYC,
  parameter int PE_CYC     = sfp_pkg::PE_CYC,
  parameter int BLK4K_CYC  = sfp_pkg::BLK4K_CYC,
  parameter int BLK32K_CYC = sfp_pkg::BLK32K_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             spi_sck,
  input  wire logic             spi_cs_n,
  input  wire logic             spi_mosi,
  input  wire logic             array_protect_bit,
  input  wire logic [7:0]       arr_rdata,
  output sfp_pkg::sfp_arr_req_t arr_req,
  output logic                  ready_busy_bit,
  output logic                  write_enable_latch,
  output logic                  program_erase_error_flag
);
  sfp_pkg::sfp_rx_t     rx;
  logic                 cs_fall, cs_rise, partial;
  sfp_pkg::sfp_state_t  st_q;
  logic [7:0]           op_q;
  logic [23:0]          addr_q;
  logic [2:0]           cnt_q;
  logic [2:0]           close_q;
  logic [7:0]           wr_ptr_q;
  logic [7:0]           buf_q [256];
  logic [255:0]         valid_q;
  logic [7:0]           idx_q;
  logic [23:0]          vaddr_q;
  logic [16:0]          vrem_q;
  logic                 chk_q;
  logic [7:0]           exp_q;
  logic [23:0]          tmr_q;
  logic                 prot_q;
  logic                 busy_q, wel_q, epe_q;
  sfp_pkg::sfp_arr_req_t arr_q;

  sfp_spi_link u_link (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .spi_sck  (spi_sck),
    .spi_cs_n (spi_cs_n),
    .spi_mosi (spi_mosi),
    .rx       (rx),
    .cs_fall  (cs_fall),
    .cs_rise  (cs_rise),
    .partial  (partial)
  );

  // Opcode decode
  wire is_prog  = (op_q == sfp_pkg::OP_PROGRAM);
  wire is_page  = (op_q == sfp_pkg::OP_PAGE_ERASE);
  wire is_b4k   = (op_q == sfp_pkg::OP_BLK4K);
  wire is_b32k  = (op_q == sfp_pkg::OP_BLK32K_A) || (op_q == sfp_pkg::OP_BLK32K_B);
  wire is_erase = is_page | is_b4k | is_b32k;
  wire is_wren  = (op_q == sfp_pkg::OP_WREN);
  wire is_wrdi  = (op_q == sfp_pkg::OP_WRDI);

  // Frame closing decision, taken once the last byte has crossed
  wire decide   = (st_q == sfp_pkg::ST_CLOSE) && (close_q == 3'h0);
  wire aligned  = ~partial;
  wire prog_len = (cnt_q >= sfp_pkg::PROG_MIN_BYTES);
  wire ers_len  = (cnt_q >= sfp_pkg::ERASE_MIN_BYTES);
  wire prog_ok  = is_prog & aligned & prog_len & wel_q & ~prot_q;
  wire ers_ok   = is_erase & aligned & ers_len & wel_q & ~prot_q;
  wire go       = decide & (prog_ok | ers_ok);
  wire wr_abort = decide & ((is_prog & (~aligned | ~prog_len | prot_q))
                          | (is_erase & (~aligned | ~ers_len | prot_q)));
  wire wel_set  = decide & is_wren & aligned & (cnt_q != 3'h0);
  wire wel_clr  = go | wr_abort | (decide & is_wrdi & aligned & (cnt_q != 3'h0));

  // Data bytes of a program frame go to the page buffer
  wire data_wr  = rx.stb && is_prog && (cnt_q >= 3'h4)
               && ((st_q == sfp_pkg::ST_RECV) || (st_q == sfp_pkg::ST_CLOSE));
  wire addr_wr  = rx.stb && (cnt_q < 3'h4)
               && ((st_q == sfp_pkg::ST_RECV) || (st_q == sfp_pkg::ST_CLOSE));

  // Erase region base and length
  wire [23:0] ers_base = is_page ? {7'h00, addr_q[16:8], 8'h00}
                       : is_b4k  ? {addr_q[23:12], 12'h000}
                       :           {addr_q[23:15], 15'h0000};
  wire [16:0] ers_len_b = is_page ? sfp_pkg::LEN_PAGE
                        : is_b4k  ? sfp_pkg::LEN_BLK4K : sfp_pkg::LEN_BLK32K;
  wire sfp_pkg::sfp_arr_op_t ers_op = is_page ? sfp_pkg::ARR_ERASE_PAGE
                                    : is_b4k  ? sfp_pkg::ARR_ERASE_4K
                                    :           sfp_pkg::ARR_ERASE_32K;
  wire [23:0] op_time = is_prog ? ((cnt_q == sfp_pkg::PROG_MIN_BYTES) ?
                                   24'(BP_CYC) : 24'(PP_CYC))
                      : is_page ? 24'(PE_CYC)
                      : is_b4k  ? 24'(BLK4K_CYC) : 24'(BLK32K_CYC);

  // Verify walk: program checks only buffered bytes, erase checks every byte
  wire       vread  = is_prog ? valid_q[vaddr_q[7:0]] : 1'b1;
  wire [7:0] vexp   = is_prog ? buf_q[vaddr_q[7:0]] : sfp_pkg::ERASED_BYTE;
  wire       vfail  = chk_q && (arr_rdata != exp_q);

  // Sequencer state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q    <= sfp_pkg::ST_IDLE;
      close_q <= 3'h0;
    end else begin
      case (st_q)
        sfp_pkg::ST_IDLE:   if (cs_fall) st_q <= sfp_pkg::ST_RECV;
        sfp_pkg::ST_RECV: begin
          if (cs_rise) begin
            st_q    <= sfp_pkg::ST_CLOSE;
            close_q <= sfp_pkg::CLOSE_WAIT;
          end
        end
        sfp_pkg::ST_CLOSE: begin
          close_q <= close_q - 3'h1;
          if (decide) st_q <= go ? sfp_pkg::ST_WRITE : sfp_pkg::ST_IDLE;
        end
        sfp_pkg::ST_WRITE:  if (is_erase || idx_q == 8'hff) st_q <= sfp_pkg::ST_VERIFY;
        sfp_pkg::ST_VERIFY: if (vrem_q == 17'h0 && !chk_q) st_q <= sfp_pkg::ST_WAIT;
        sfp_pkg::ST_WAIT:   if (tmr_q == 24'h0) st_q <= sfp_pkg::ST_IDLE;
        default:            st_q <= sfp_pkg::ST_IDLE;
      endcase
    end
  end

  // Frame capture: opcode, address, byte count; frames seen while busy are dropped
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_q     <= 8'h00;
      addr_q   <= 24'h0;
      cnt_q    <= 3'h0;
      wr_ptr_q <= 8'h00;
    end else if (st_q == sfp_pkg::ST_IDLE && cs_fall) begin
      cnt_q <= 3'h0;
    end else if (rx.stb && (st_q == sfp_pkg::ST_RECV || st_q == sfp_pkg::ST_CLOSE)) begin
      if (cnt_q != sfp_pkg::CNT_SAT) cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h0) op_q <= rx.data;
      if (addr_wr && cnt_q != 3'h0) addr_q <= {addr_q[15:0], rx.data};
      if (addr_wr && cnt_q == 3'h3) wr_ptr_q <= rx.data;
      if (data_wr) wr_ptr_q <= wr_ptr_q + 8'h01;
    end
  end

  // Page buffer; validity cleared when the opcode byte of a frame arrives in ST_RECV
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q <= '0;
    end else if (rx.stb && st_q == sfp_pkg::ST_RECV && cnt_q == 3'h0) begin
      valid_q <= '0;
    end else if (data_wr) begin
      valid_q[wr_ptr_q] <= 1'b1;
    end
  end

  // Buffer storage; last 256 bytes win by overwrite
  always_ff @(posedge sys_clk) begin
    if (data_wr) buf_q[wr_ptr_q] <= rx.data;
  end

  // Array request, write walk and verify walk
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arr_q   <= '0;
      idx_q   <= 8'h00;
      vaddr_q <= 24'h0;
      vrem_q  <= 17'h0;
      chk_q   <= 1'b0;
      exp_q   <= 8'h00;
    end else begin
      arr_q.op <= sfp_pkg::ARR_IDLE;
      chk_q    <= 1'b0;
      if (go) begin
        idx_q <= 8'h00;
      end else if (st_q == sfp_pkg::ST_WRITE && is_prog) begin
        if (valid_q[idx_q]) begin
          arr_q <= '{sfp_pkg::ARR_WRITE, {addr_q[23:8], idx_q}, buf_q[idx_q]};
        end
        idx_q   <= idx_q + 8'h01;
        vaddr_q <= {addr_q[23:8], 8'h00};
        vrem_q  <= sfp_pkg::LEN_PAGE;
      end else if (st_q == sfp_pkg::ST_WRITE) begin
        arr_q   <= '{ers_op, ers_base, sfp_pkg::ERASED_BYTE};
        vaddr_q <= ers_base;
        vrem_q  <= ers_len_b;
      end else if (st_q == sfp_pkg::ST_VERIFY && vrem_q != 17'h0) begin
        if (vread) begin
          arr_q <= '{sfp_pkg::ARR_READ, vaddr_q, 8'h00};
        end
        chk_q   <= vread;
        exp_q   <= vexp;
        vaddr_q <= vaddr_q + 24'h1;
        vrem_q  <= vrem_q - 17'h1;
      end
    end
  end

  // Status bits and self-timer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      wel_q  <= 1'b0;
      epe_q  <= 1'b0;
      tmr_q  <= 24'h0;
      prot_q <= 1'b0;
    end else begin
      prot_q <= array_protect_bit;
      if (tmr_q != 24'h0) tmr_q <= tmr_q - 24'h1;
      if (go) begin
        busy_q <= 1'b1;
        tmr_q  <= op_time;
        epe_q  <= 1'b0;
      end else if (st_q == sfp_pkg::ST_WAIT && tmr_q == 24'h0) begin
        busy_q <= 1'b0;
      end
      if (vfail) epe_q <= 1'b1;
      if (wel_set) wel_q <= 1'b1;
      else if (wel_clr) wel_q <= 1'b0;
    end
  end

  assign arr_req                  = arr_q;
  assign ready_busy_bit           = busy_q;
  assign write_enable_latch       = wel_q;
  assign program_erase_error_flag = epe_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_go;
    decide && (prog_ok || ers_ok);
  endsequence
  sequence s_busy2;
    busy_q ##1 busy_q;
  endsequence

  property p_busy_start;
    s_go |=> s_busy2;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not held after start");

  property p_wel_clear;
    $rose(busy_q) |-> !wel_q;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch still set when busy");

  property p_short_prog;
    decide && is_prog && cnt_q < sfp_pkg::PROG_MIN_BYTES |=> !busy_q && !wel_q;
  endproperty
  a_short_prog: assert property (p_short_prog) else $error("short program not aborted");

  property p_misalign;
    decide && (is_prog || is_erase) && partial |=> !busy_q && !wel_q;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned release executed");

  property p_protect;
    decide && prot_q && (is_prog || is_erase) |=> !busy_q && st_q == sfp_pkg::ST_IDLE;
  endproperty
  a_protect: assert property (p_protect) else $error("protected array altered");

  property p_wren;
    decide && is_wren && !partial && cnt_q != 3'h0 |=> wel_q;
  endproperty
  a_wren: assert property (p_wren) else $error("write enable not latched");

  property p_wrap;
    data_wr |=> wr_ptr_q == $past(wr_ptr_q) + 8'h01;
  endproperty
  a_wrap: assert property (p_wrap) else $error("buffer pointer did not wrap");

  property p_only_valid;
    arr_q.op == sfp_pkg::ARR_WRITE |-> valid_q[arr_q.addr[7:0]];
  endproperty
  a_only_valid: assert property (p_only_valid) else $error("unsent byte programmed");

  property p_blk_align;
    arr_q.op == sfp_pkg::ARR_ERASE_4K |-> arr_q.addr[11:0] == 12'h000;
  endproperty
  a_blk_align: assert property (p_blk_align) else $error("4k erase base not aligned");

  property p_epe;
    st_q == sfp_pkg::ST_VERIFY && vfail |=> epe_q;
  endproperty
  a_epe: assert property (p_epe) else $error("failure not flagged");

  property p_busy_quiet;
    busy_q |=> $stable(op_q);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("command taken while busy");
endmodule : sfp_sequencer

// >>> verification/sfp_host_model.sv
// Link host model: sends command frames to the sequencer, mode 0, MSB first
`timescale 1ns/100ps
module sfp_host_model (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  logic [7:0] tx_q[$];

  // Link idles deselected with its clock parked low
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // Shift the first nbits of the queue; a count that is not a multiple of eight ends off a byte boundary
  task automatic send(input int nbits);
    spi_cs_n = 1'b0;
    #20;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = tx_q[i/8][7-(i%8)];
      #7.5 spi_sck = 1'b1;
      #7.5 spi_sck = 1'b0;
    end
    #20 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;            // Released line no longer holds the last bit
    tx_q.delete();
    #300;                            // Deselect gap of twelve system cycles
  endtask : send
endmodule : sfp_host_model

// >>> verification/sfp_sequencer_bench.sv
// Self-checking bench for the program and erase sequencer
`timescale 1ns/100ps
module sfp_sequencer_bench;
  logic                  sys_clk;
  logic                  sys_rst;
  logic                  array_protect_bit;
  logic                  bad_rd;
  logic                  spi_sck;
  logic                  spi_cs_n;
  logic                  spi_mosi;
  logic [7:0]            arr_rdata;
  sfp_pkg::sfp_arr_req_t arr_req;
  logic                  ready_busy_bit;
  logic                  write_enable_latch;
  logic                  program_erase_error_flag;
  logic                  saw_busy;
  logic                  wel_busy;
  int                    n_fail;
  int                    n_checks;
  int                    n_wr;
  logic [7:0]            mem [logic [23:0]];
  sfp_pkg::sfp_arr_req_t ops[$];

  // 40 MHz system clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  sfp_host_model i_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

  sfp_sequencer #(.BP_CYC(50), .PP_CYC(50), .PE_CYC(50), .BLK4K_CYC(50), .BLK32K_CYC(50))
  i_dut (
    .sys_clk                 (sys_clk),
    .sys_rst                 (sys_rst),
    .spi_sck                 (spi_sck),
    .spi_cs_n                (spi_cs_n),
    .spi_mosi                (spi_mosi),
    .array_protect_bit       (array_protect_bit),
    .arr_rdata               (arr_rdata),
    .arr_req                 (arr_req),
    .ready_busy_bit          (ready_busy_bit),
    .write_enable_latch      (write_enable_latch),
    .program_erase_error_flag(program_erase_error_flag)
  );

  // Array model: unwritten bytes read erased, a forced fault reads zero
  function automatic logic [7:0] rd_mem(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : sfp_pkg::ERASED_BYTE;
  endfunction : rd_mem
  // Array model output; the update count forces a fresh look after each model change
  always @(arr_req or bad_rd or n_wr) arr_rdata = bad_rd ? 8'h00 : rd_mem(arr_req.addr);

  // Log writes and erases; an erase wipes the whole model for simplicity
  always @(posedge sys_clk) begin
    if (ready_busy_bit === 1'b1) saw_busy = 1'b1;
    if (ready_busy_bit === 1'b1 && write_enable_latch !== 1'b0) wel_busy = 1'b1;
    if (arr_req.op == sfp_pkg::ARR_WRITE) begin
      mem[arr_req.addr] = arr_req.data;
      n_wr++;
      ops.push_back(arr_req);
    end else if (arr_req.op inside {sfp_pkg::ARR_ERASE_PAGE, sfp_pkg::ARR_ERASE_4K,
                                    sfp_pkg::ARR_ERASE_32K}) begin
      ops.push_back(arr_req);
      mem.delete();
      n_wr++;
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Data byte k of a frame; bytes past 256 carry a distinct value
  function automatic logic [7:0] dat(input int k);
    return (k > 255) ? 8'h33 : (8'(k) ^ 8'ha5);
  endfunction : dat

  task automatic cmd(input logic [31:0] hdr, input int nhdr, input int ndata, input int nbits);
    for (int i = 0; i < nhdr; i++) i_host.tx_q.push_back(hdr[31-8*i -: 8]);
    for (int k = 0; k < ndata; k++) i_host.tx_q.push_back(dat(k));
    i_host.send(nbits > 0 ? nbits : 8 * (nhdr + ndata));
  endtask : cmd

  task automatic begin_t();
    ops.delete();
    mem.delete();
    n_wr++;
    saw_busy = 1'b0;
    wel_busy = 1'b0;
  endtask : begin_t

  // Let the decision land, then wait out busy under a bound
  task automatic settle();
    int k;
    repeat (30) @(posedge sys_clk);
    k = 0;
    while (ready_busy_bit !== 1'b0 && k < 40000) begin
      @(posedge sys_clk);
      k++;
    end
    #1;
    chk(ready_busy_bit, 1'b0);
  endtask : settle

  task automatic wren();
    cmd(32'h06000000, 1, 0, 0);
  endtask : wren

  task automatic t_prog_one();
    begin_t();
    wren();
    chk(write_enable_latch, 1'b1);
    cmd(32'h020000fe, 4, 1, 0);
    settle();
    chk(ops.size(), 1);
    chk(rd_mem(24'h0000fe), 8'ha5);
    chk({saw_busy, wel_busy}, 2'b10);
    chk({write_enable_latch, program_erase_error_flag}, 2'b00);
    $display("test prog_one done");
  endtask : t_prog_one

  task automatic t_wrap_over();
    begin_t();
    wren();
    cmd(32'h020000fe, 4, 3, 0);
    settle();
    chk(ops.size(), 3);
    chk({rd_mem(24'h0000fe), rd_mem(24'h0000ff), rd_mem(24'h000000)}, 24'ha5a4a7);
    chk(rd_mem(24'h000001), 8'hff);
    begin_t();
    wren();
    cmd(32'h02000100, 4, 258, 0);
    settle();
    chk(ops.size(), 256);
    chk({rd_mem(24'h000100), rd_mem(24'h000101)}, 16'h3333);
    chk({rd_mem(24'h000102), rd_mem(24'h0001ff)}, 16'ha75a);
    $display("test wrap_over done");
  endtask : t_wrap_over

  task automatic t_abort();
    int cut[3] = '{24, 36, 44};
    for (int i = 0; i < 3; i++) begin
      begin_t();
      wren();
      cmd(32'h02000200, 4, 2, cut[i]);
      settle();
      chk({ops.size() == 0, saw_busy, write_enable_latch}, 3'b100);
    end
    begin_t();
    wren();
    cmd(32'h20123456, 4, 0, 28);
    settle();
    chk({ops.size() == 0, saw_busy, write_enable_latch}, 3'b100);
    $display("test abort done");
  endtask : t_abort

  task automatic t_gate();
    begin_t();
    wren();
    cmd(32'h04000000, 1, 0, 0);
    chk(write_enable_latch, 1'b0);
    cmd(32'h02000000, 4, 1, 0);
    cmd(32'h20000000, 4, 0, 0);
    settle();
    chk({ops.size() == 0, saw_busy}, 2'b10);
    @(posedge sys_clk) array_protect_bit <= 1'b1;
    wren();
    cmd(32'h02000000, 4, 1, 0);
    settle();
    chk({ops.size() == 0, saw_busy, write_enable_latch}, 3'b100);
    wren();
    cmd(32'hd8000000, 4, 0, 0);
    settle();
    chk({ops.size() == 0, saw_busy, write_enable_latch}, 3'b100);
    @(posedge sys_clk) array_protect_bit <= 1'b0;
    $display("test gate done");
  endtask : t_gate

  task automatic t_erase();
    logic [31:0] hdr[4] = '{32'h81012345, 32'h20aabbcc, 32'h52abcdef, 32'hd8017fff};
    logic [26:0] exp[4] = '{{sfp_pkg::ARR_ERASE_PAGE, 24'h012300},
                            {sfp_pkg::ARR_ERASE_4K, 24'haab000},
                            {sfp_pkg::ARR_ERASE_32K, 24'hab8000},
                            {sfp_pkg::ARR_ERASE_32K, 24'h010000}};
    for (int i = 0; i < 4; i++) begin
      begin_t();
      wren();
      cmd(hdr[i], 4, (i == 3) ? 1 : 0, 0);                // Trailing byte ignored
      settle();
      chk(ops.size(), 1);
      if (ops.size() > 0) chk({ops[0].op, ops[0].addr}, exp[i]);
      chk({saw_busy, wel_busy, write_enable_latch}, 3'b100);
      chk(program_erase_error_flag, 1'b0);
    end
    $display("test erase done");
  endtask : t_erase

  task automatic t_error();
    logic [2:0] bad[3]   = '{3'h1, 3'h0, 3'h1};
    logic [31:0] hdr[3]  = '{32'h02000300, 32'h02000300, 32'h81000500};
    for (int i = 0; i < 3; i++) begin
      begin_t();
      @(posedge sys_clk) bad_rd <= bad[i][0];
      wren();
      cmd(hdr[i], 4, (i < 2) ? 1 : 0, 0);
      settle();
      chk(program_erase_error_flag, bad[i][0]);
    end
    @(posedge sys_clk) bad_rd <= 1'b0;
    $display("test error done");
  endtask : t_error

  task automatic t_busy();
    int k;
    begin_t();
    wren();
    cmd(32'h02000400, 4, 1, 0);
    k = 0;
    while (ready_busy_bit !== 1'b1 && k < 40) begin
      @(posedge sys_clk);
      k++;
    end
    chk(ready_busy_bit, 1'b1);
    wren();
    cmd(32'h20000000, 4, 0, 0);
    chk(write_enable_latch, 1'b0);
    settle();
    chk({ops.size(), write_enable_latch}, 33'h2);
    $display("test busy done");
  endtask : t_busy

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Watchdog above the expected run of about 75000 cycles
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end

  // Main sequence
  initial begin
    n_fail            = 0;
    n_checks          = 0;
    n_wr              = 0;
    sys_rst           <= 1'b1;
    array_protect_bit = 1'b0;
    bad_rd            = 1'b0;
    saw_busy          = 1'b0;
    wel_busy          = 1'b0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #3;
    t_prog_one();
    t_wrap_over();
    t_abort();
    t_gate();
    t_erase();
    t_error();
    t_busy();
    print_verdict();
  end
endmodule : sfp_sequencer_bench
